//--- hdl/sadc_pkg.sv
package sadc_pkg;
   // register indices on the byte-wide register port
   localparam logic [2:0] A_CTRL0 = 3'h0;
   localparam logic [2:0] A_CTRL1 = 3'h1;
   localparam logic [2:0] A_RESH = 3'h2;
   localparam logic [2:0] A_RESL = 3'h3;
   localparam logic [2:0] A_FREF = 3'h4;
   localparam logic [2:0] A_FLAG = 3'h5;
   localparam logic [2:0] A_IEN = 3'h6;
   // converter_control_0
   localparam int B_ON = 0;
   localparam int B_GO = 1;
   localparam int B_CHS = 2;
   // converter_control_1
   localparam int B_FMT = 7;
   localparam int B_CS = 4;
   localparam int B_PREF = 0;
   localparam logic [7:0] CTRL1_MASK = 8'hf3;
   // fixed_reference_control
   localparam int B_RDY = 6;
   localparam int B_SENSOR_ENABLE = 5;
   localparam int B_SENSOR_RANGE_SELECT = 4;
   localparam logic [7:0] FREF_MASK = 8'hbf;
   // flag and enable registers
   localparam int B_DONE = 0;
   localparam int B_IE = 0;
   localparam int B_PERIPHERAL_IRQ_ENABLE = 1;
   localparam int B_GIE = 2;
   // channel codes and routed sources
   localparam logic [4:0] CH_TEMP = 5'h1d;
   localparam logic [4:0] CH_DAC = 5'h1e;
   localparam logic [4:0] CH_FVR = 5'h1f;
   localparam logic [2:0] SRC_TEMP = 3'h4;
   localparam logic [2:0] SRC_DAC = 3'h5;
   localparam logic [2:0] SRC_FVR = 3'h6;
   localparam logic [2:0] SRC_NONE = 3'h7;
   // positive reference codes
   localparam logic [1:0] REF_VDD = 2'h0;
   localparam logic [1:0] REF_PIN = 2'h1;
   localparam logic [1:0] REF_F2V = 2'h2;
   localparam logic [1:0] REF_F4V = 2'h3;
   // conversion timing in half bit periods: 1.5 + 10 x 1 = 11.5
   localparam logic [1:0] HOLD_HALF = 2'h3;
   localparam logic [1:0] BIT_HALF = 2'h2;
   localparam logic [4:0] LAST_HALF = 5'h16;
   localparam logic [3:0] MSB_IDX = 4'h9;
   typedef enum logic [1:0] {SADC_IDLE, SADC_HOLD, SADC_BITS} sadc_state_t;
endpackage

//--- hdl/sadc_top.sv
`timescale 1ns/10ps
// Overview of operation
// R1: successive approximation yields a 10-bit result, loaded into result pair at end.
// R2: seven sources: four pins, temperature sensor, DAC output, fixed reference.
// R3: channel select field routes one source to the sample-and-hold.
// R4: channel code 29 routes the temperature sensor.
// R5: software waits an acquisition delay after changing channel.
// R6: software waits 200 us after selecting sensor and between its conversions.
// R7: positive reference: pin, supply, 2.048V or 4.096V; 4.096V absent on low-voltage.
// R8: clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC.
// R9: one bit period per clock period; a conversion takes 11.5 bit periods.
// R10: divider clocks follow the system clock; RC clock is independent.
// R11: conversions run in sleep only with the RC clock; otherwise aborted.
// R12: completion flag set at end of every conversion regardless of enable.
// R13: software clears the completion flag; irq enable gates the request.
// R14: enabled completion wakes the device from sleep.
// R15: after wake, vector when global and peripheral enables set, else in line.
// R16: result format bit selects left or right justification.
// R17: bit 5 of fixed reference control turns the sensor on.
// R18: bit 4 of fixed reference control selects high sensor range.
// R19: converter runs only when on; writing start bit begins a conversion.
// R20: at end: start bit cleared, flag set, result registers loaded.
// R21: clearing start bit mid-conversion loads partial result, rest copy last bit.
// R22: bits resolved msb first, one per bit period, after the hold period.
// R23: unused result bits read zero in either justification.
// R24: reset clears control bits, turns converter off, abandons conversion.
module sadc_top #(
   parameter bit HAS_4V = 1'b1
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic comp_in,
   input wire logic rc_tick,
   input wire logic sleep_in,
   input wire logic ref_ready_in,
   output logic [2:0] src_sel,
   output logic [9:0] trial_code,
   output logic sh_hold,
   output logic [1:0] pos_ref_sel,
   output logic reference_enable,
   output logic sensor_enable,
   output logic sensor_range_select,
   output logic [1:0] comparator_dac_ref_gain,
   output logic [1:0] converter_ref_gain,
   output logic irq_req,
   output logic wake,
   output logic irq_vector
);
   sadc_pkg::sadc_state_t state_ff;
   logic on_ff, go_ff, flag_ff;
   logic [4:0] chs_ff;
   logic [7:0] ctrl1_ff, fref_ff, rdata_ff;
   logic [2:0] ien_ff, src_ff;
   logic [1:0] ref_ff, phase_ff;
   logic [9:0] sar_ff, res_ff;
   logic [3:0] idx_ff;
   logic [4:0] div_ff, half_cnt_ff;
   logic hold_ff, irq_ff, wake_ff, vec_ff;
   logic [2:0] cs;
   logic rc_sel, half_tick, busy, wr0, go_clr, kill, done_now, start;

   function automatic logic [4:0] half_lim(input logic [2:0] code);
      unique case (code)
         3'b000: half_lim = 5'h00;
         3'b100: half_lim = 5'h01;
         3'b001: half_lim = 5'h03;
         3'b101: half_lim = 5'h07;
         3'b010: half_lim = 5'h0f;
         3'b110: half_lim = 5'h1f;
         default: half_lim = 5'h00;
      endcase
   endfunction

   // unconverted bits copy the last resolved one; nothing resolved gives zero
   function automatic logic [9:0] partial(input logic [9:0] s, input logic [3:0] i);
      logic [9:0] r;
      r = s;
      for (int k = 0; k < 10; k++) begin
         if (k[3:0] <= i) begin
            r[k] = (i == sadc_pkg::MSB_IDX) ? 1'b0 : s[i + 4'h1];
         end
      end
      return r;
   endfunction

   assign cs = ctrl1_ff[sadc_pkg::B_CS +: 3];
   assign rc_sel = (cs[1:0] == 2'b11); // [R8]
   // divider runs off core_clk so it tracks any change in its rate [R10]
   assign half_tick = rc_sel ? rc_tick : (div_ff == half_lim(cs)); // [R10]
   assign busy = (state_ff != sadc_pkg::SADC_IDLE);
   assign wr0 = reg_wr && (reg_addr == sadc_pkg::A_CTRL0);
   assign go_clr = wr0 && !reg_wdata[sadc_pkg::B_GO];
   // sleep stops any non-RC conversion; turning off abandons one too
   assign kill = busy && ((sleep_in && !rc_sel) || (wr0 && !reg_wdata[sadc_pkg::B_ON])); // [R11]
   assign done_now = (state_ff == sadc_pkg::SADC_BITS) && half_tick && !kill
      && (phase_ff == sadc_pkg::BIT_HALF - 2'h1) && (idx_ff == 4'h0);
   assign start = !busy && go_ff && on_ff && !(sleep_in && !rc_sel); // [R19]

   always_ff @(posedge core_clk) begin
      if (srst || !busy || half_tick) begin
         div_ff <= 5'h00;
      end else begin
         div_ff <= div_ff + 5'h01;
      end
   end

   // control registers written by software
   always_ff @(posedge core_clk) begin
      if (srst) begin
         on_ff <= 1'b0; // [R24]
         chs_ff <= 5'h00;
         ctrl1_ff <= 8'h00;
         fref_ff <= 8'h00;
         ien_ff <= 3'h0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            sadc_pkg::A_CTRL0: begin
               on_ff <= reg_wdata[sadc_pkg::B_ON];
               chs_ff <= reg_wdata[sadc_pkg::B_CHS +: 5]; // [R3]
            end
            sadc_pkg::A_CTRL1: ctrl1_ff <= reg_wdata & sadc_pkg::CTRL1_MASK;
            sadc_pkg::A_FREF: fref_ff <= reg_wdata & sadc_pkg::FREF_MASK; // [R17] [R18]
            sadc_pkg::A_IEN: ien_ff <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   // source routing and reference choice, registered for clean outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         src_ff <= 3'h0;
         ref_ff <= sadc_pkg::REF_VDD;
      end else begin
         if (chs_ff < 5'h04) begin
            src_ff <= chs_ff[2:0]; // [R2]
         end else if (chs_ff == sadc_pkg::CH_TEMP) begin
            src_ff <= sadc_pkg::SRC_TEMP; // [R4]
         end else if (chs_ff == sadc_pkg::CH_DAC) begin
            src_ff <= sadc_pkg::SRC_DAC; // [R2]
         end else if (chs_ff == sadc_pkg::CH_FVR) begin
            src_ff <= sadc_pkg::SRC_FVR; // [R2]
         end else begin
            src_ff <= sadc_pkg::SRC_NONE;
         end
         // the 4.096V choice falls back to the supply on low-voltage parts
         if (!HAS_4V && ctrl1_ff[1:0] == sadc_pkg::REF_F4V) begin
            ref_ff <= sadc_pkg::REF_VDD; // [R7]
         end else begin
            ref_ff <= ctrl1_ff[sadc_pkg::B_PREF +: 2]; // [R7]
         end
      end
   end

   // conversion sequencer and start/done bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_ff <= sadc_pkg::SADC_IDLE; // [R24]
         go_ff <= 1'b0;
         phase_ff <= 2'h0;
         idx_ff <= sadc_pkg::MSB_IDX;
         sar_ff <= 10'h000;
         res_ff <= 10'h000;
         hold_ff <= 1'b0;
         half_cnt_ff <= 5'h00;
      end else if (kill) begin
         state_ff <= sadc_pkg::SADC_IDLE; // [R11]
         go_ff <= 1'b0;
         hold_ff <= 1'b0;
      // a completion in the same cycle wins over the clear
      end else if (busy && go_clr && !done_now) begin
         state_ff <= sadc_pkg::SADC_IDLE;
         go_ff <= 1'b0;
         hold_ff <= 1'b0;
         if (state_ff == sadc_pkg::SADC_BITS) begin
            res_ff <= partial(sar_ff, idx_ff); // [R21]
         end else begin
            res_ff <= 10'h000; // [R21]
         end
      end else begin
         unique case (state_ff)
            sadc_pkg::SADC_IDLE: begin
               if (wr0) begin
                  go_ff <= reg_wdata[sadc_pkg::B_GO] && reg_wdata[sadc_pkg::B_ON] && on_ff; // [R19]
               end
               if (start) begin
                  state_ff <= sadc_pkg::SADC_HOLD;
                  phase_ff <= 2'h0;
                  half_cnt_ff <= 5'h00;
                  hold_ff <= 1'b1;
               end
            end
            sadc_pkg::SADC_HOLD: begin
               if (half_tick) begin
                  half_cnt_ff <= half_cnt_ff + 5'h01;
                  if (phase_ff == sadc_pkg::HOLD_HALF - 2'h1) begin
                     state_ff <= sadc_pkg::SADC_BITS; // [R22]
                     phase_ff <= 2'h0;
                     idx_ff <= sadc_pkg::MSB_IDX;
                     sar_ff <= 10'h200; // [R22]
                  end else begin
                     phase_ff <= phase_ff + 2'h1;
                  end
               end
            end
            sadc_pkg::SADC_BITS: begin
               if (half_tick) begin
                  half_cnt_ff <= half_cnt_ff + 5'h01; // [R9]
                  if (phase_ff == sadc_pkg::BIT_HALF - 2'h1) begin
                     phase_ff <= 2'h0;
                     sar_ff[idx_ff] <= comp_in; // [R22]
                     if (idx_ff == 4'h0) begin
                        state_ff <= sadc_pkg::SADC_IDLE;
                        go_ff <= 1'b0; // [R20]
                        hold_ff <= 1'b0;
                        res_ff <= {sar_ff[9:1], comp_in}; // [R1] [R20]
                     end else begin
                        idx_ff <= idx_ff - 4'h1;
                        sar_ff[idx_ff - 4'h1] <= 1'b1;
                     end
                  end else begin
                     phase_ff <= phase_ff + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   // completion flag: the hardware set beats a software clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         flag_ff <= 1'b0;
      end else if (done_now) begin
         flag_ff <= 1'b1; // [R12] [R20]
      end else if (reg_wr && reg_addr == sadc_pkg::A_FLAG) begin
         flag_ff <= reg_wdata[sadc_pkg::B_DONE]; // [R13]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
         vec_ff <= 1'b0;
      end else begin
         irq_ff <= flag_ff && ien_ff[sadc_pkg::B_IE]; // [R13]
         wake_ff <= done_now && sleep_in && ien_ff[sadc_pkg::B_IE]; // [R14]
         vec_ff <= done_now && sleep_in && ien_ff[sadc_pkg::B_IE]
            && ien_ff[sadc_pkg::B_GIE] && ien_ff[sadc_pkg::B_PERIPHERAL_IRQ_ENABLE]; // [R15]
      end
   end

   // read data stands one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (srst || !reg_rd) begin
         rdata_ff <= 8'h00;
      end else begin
         unique case (reg_addr)
            sadc_pkg::A_CTRL0: rdata_ff <= {1'b0, chs_ff, go_ff, on_ff};
            sadc_pkg::A_CTRL1: rdata_ff <= ctrl1_ff;
            sadc_pkg::A_RESH: rdata_ff <= ctrl1_ff[sadc_pkg::B_FMT] ?
               {6'h00, res_ff[9:8]} : res_ff[9:2]; // [R16] [R23]
            sadc_pkg::A_RESL: rdata_ff <= ctrl1_ff[sadc_pkg::B_FMT] ?
               res_ff[7:0] : {res_ff[1:0], 6'h00}; // [R16] [R23]
            sadc_pkg::A_FREF: rdata_ff <= fref_ff | {1'b0, ref_ready_in, 6'h00};
            sadc_pkg::A_FLAG: rdata_ff <= {7'h00, flag_ff};
            sadc_pkg::A_IEN: rdata_ff <= {5'h00, ien_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_ff;
   assign src_sel = src_ff;
   assign trial_code = sar_ff;
   assign sh_hold = hold_ff;
   assign pos_ref_sel = ref_ff;
   assign reference_enable = fref_ff[7];
   assign sensor_enable = fref_ff[sadc_pkg::B_SENSOR_ENABLE];
   assign sensor_range_select = fref_ff[sadc_pkg::B_SENSOR_RANGE_SELECT];
   assign comparator_dac_ref_gain = fref_ff[3:2];
   assign converter_ref_gain = fref_ff[1:0];
   assign irq_req = irq_ff;
   assign wake = wake_ff;
   assign irq_vector = vec_ff;

   sequence s_done;
      done_now ##1 flag_ff;
   endsequence

   AST_GO_NEEDS_ON: assert property (@(posedge core_clk) disable iff (srst) // [R19]
      go_ff |-> on_ff) else $error("start bit set while converter off");
   AST_DONE: assert property (@(posedge core_clk) disable iff (srst) // [R20]
      done_now |-> s_done ##0 !go_ff) else $error("completion did not flag or clear start");
   AST_LSB: assert property (@(posedge core_clk) disable iff (srst) // [R1]
      done_now |=> res_ff[0] == $past(comp_in)) else $error("last bit not loaded");
   AST_LEN: assert property (@(posedge core_clk) disable iff (srst) // [R9]
      done_now |-> half_cnt_ff == sadc_pkg::LAST_HALF) else $error("conversion length wrong");
   AST_SLEEP: assert property (@(posedge core_clk) disable iff (srst) // [R11]
      (busy && sleep_in && !rc_sel) |=> !busy && !go_ff) else $error("sleep did not abort");
   AST_TEMP: assert property (@(posedge core_clk) disable iff (srst) // [R4]
      chs_ff == sadc_pkg::CH_TEMP |=> src_ff == sadc_pkg::SRC_TEMP) else $error("temp route");
   AST_RJUST: assert property (@(posedge core_clk) disable iff (srst) // [R23]
      (reg_rd && reg_addr == sadc_pkg::A_RESH && ctrl1_ff[sadc_pkg::B_FMT])
      |=> reg_rdata[7:2] == 6'h00) else $error("unused high bits not zero");
   AST_WAKE: assert property (@(posedge core_clk) disable iff (srst) // [R14]
      wake |-> $past(sleep_in) && $past(done_now)) else $error("wake without completion");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (srst) // [R12]
      (flag_ff && !(reg_wr && reg_addr == sadc_pkg::A_FLAG)) |=> flag_ff)
      else $error("flag lost");
   AST_RESET: assert property (@(posedge core_clk) // [R24]
      srst |=> !on_ff && !go_ff && !busy) else $error("reset left converter active");
endmodule

//--- dv/sadc_afe_model.sv
`timescale 1ns/10ps
module sadc_afe_model (
   input wire logic core_clk,
   input wire logic [2:0] src_sel,
   input wire logic [9:0] trial_code,
   input wire logic sh_hold,
   input wire logic [79:0] vin_all,
   output logic comp_in
);
   logic [9:0] held = 10'h000;
   logic hold_d = 1'b0;
   logic junk = 1'b0;
   // capture the routed source as the hold phase begins
   always @(posedge core_clk) begin
      hold_d <= sh_hold;
      junk <= ~junk;
      if (sh_hold && !hold_d)
         held <= vin_all[src_sel*10 +: 10];
   end
   // outside a conversion the comparator output means nothing, so it wanders
   assign comp_in = sh_hold ? (held >= trial_code) : junk;
endmodule

//--- dv/sar_adc_control_tb_top.sv
`timescale 1ns/10ps
module sar_adc_control_tb_top;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rc_tick = 1'b0;
   logic sleep_in = 1'b0;
   logic ref_rdy = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [79:0] vin_all = 80'h0;
   logic [2:0] src_sel, ien;
   logic [7:0] reg_rdata, d, h, l;
   logic [9:0] trial_code, v, r;
   logic [1:0] pos_ref_sel, cg, ag;
   logic comp_in, sh_hold, ren, sen, srs, irq_req, wake, irq_vector, ok;
   logic [4:0] channel_select [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e, 5'h1f, 5'h05};
   logic [15:0] exp_q [$];
   int num_errors = 0;
   int cmp_count = 0;
   int seed = 40;
   int hold_cnt = 0;
   int wake_cnt = 0;
   int vec_cnt = 0;
   int rc_n = 0;
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      rc_n <= (rc_n == 2) ? 0 : rc_n + 1;
      rc_tick <= (rc_n == 2);
      if (sh_hold === 1'b1) hold_cnt++;
      if (wake === 1'b1) wake_cnt++;
      if (irq_vector === 1'b1) vec_cnt++;
   end
   sadc_top dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
      .rc_tick(rc_tick), .sleep_in(sleep_in), .ref_ready_in(ref_rdy), .src_sel(src_sel),
      .trial_code(trial_code), .sh_hold(sh_hold), .pos_ref_sel(pos_ref_sel),
      .reference_enable(ren), .sensor_enable(sen), .sensor_range_select(srs),
      .comparator_dac_ref_gain(cg), .converter_ref_gain(ag), .irq_req(irq_req),
      .wake(wake), .irq_vector(irq_vector));
   sadc_afe_model afe (.core_clk(core_clk), .src_sel(src_sel), .trial_code(trial_code),
      .sh_hold(sh_hold), .vin_all(vin_all), .comp_in(comp_in));
   task automatic wr(input logic [2:0] a, input logic [7:0] dv);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dv;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] dv);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      dv = reg_rdata;
      // end on an edge so callers drive the next inputs there
      @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   function automatic logic [15:0] just(input logic [9:0] rv, input logic f);
      return f ? {6'h00, rv} : {rv, 6'h00};
   endfunction
   // cycles per half bit period: dividers give N/2, the rc ticks every 3 cycles
   function automatic int hc(input logic [2:0] cs);
      if (cs[1:0] == 2'h3) return 3;
      return 1 << {cs[1:0], cs[2]};
   endfunction
   task automatic conv(input logic [2:0] cs, input logic f, input logic [1:0] ch);
      v = 10'($random(seed));
      vin_all[ch*10 +: 10] <= v;
      exp_q.push_back(just(v, f));
      wr(sadc_pkg::A_CTRL1, {f, cs, 4'h0});
      wr(sadc_pkg::A_CTRL0, {3'h0, ch, 2'h1});
      repeat (8) @(posedge core_clk);
      hold_cnt = 0;
      wr(sadc_pkg::A_CTRL0, {3'h0, ch, 2'h3});
      d = 8'h02;
      for (int i = 0; i < 2000 && d[1] !== 1'b0; i++) rd(sadc_pkg::A_CTRL0, d);
      rd(sadc_pkg::A_RESH, h);
      rd(sadc_pkg::A_RESL, l);
      chk("result", exp_q.pop_front(), {h, l});
      chk("length", 16'h1, 16'(hold_cnt >= 22*hc(cs)-2 && hold_cnt <= 24*hc(cs)+2));
      rd(sadc_pkg::A_FLAG, d);
      chk("flag", 16'h1, {15'h0, d[0]});
      chk("irq_req", {15'h0, ien[0]}, {15'h0, irq_req});
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      wr(3'h7, 8'hff);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         chk("reset value", 16'h0, {8'h0, d});
      end
      wr(sadc_pkg::A_CTRL1, 8'hff);
      rd(sadc_pkg::A_CTRL1, d);
      chk("ctrl1", {8'h0, sadc_pkg::CTRL1_MASK}, {8'h0, d});
      for (int i = 0; i < 4; i++) begin
         l = 8'($random(seed));
         ref_rdy <= l[6];
         wr(sadc_pkg::A_FREF, l);
         rd(sadc_pkg::A_FREF, d);
         chk("fref", {8'h0, l}, {8'h0, d});
         chk("fref pins", {9'h0, l[7], l[5:0]}, {9'h0, ren, sen, srs, cg, ag});
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         wr(sadc_pkg::A_CTRL0, {1'b0, channel_select[i], 2'h0});
         repeat (2) @(posedge core_clk);
         #1;
         chk("src_sel", 16'(i), {13'h0, src_sel});
      end
      for (int i = 0; i < 4; i++) begin
         wr(sadc_pkg::A_CTRL1, 8'(i));
         repeat (2) @(posedge core_clk);
         #1;
         chk("pos_ref_sel", 16'(i), {14'h0, pos_ref_sel});
      end
      wr(sadc_pkg::A_CTRL0, 8'h02);
      rd(sadc_pkg::A_CTRL0, d);
      chk("start while off", 16'h0, {7'h0, sh_hold, d});
      $display("test selection done");
      ien = 3'h1;
      wr(sadc_pkg::A_IEN, {5'h0, ien});
      for (int i = 0; i < 8; i++) begin
         wr(sadc_pkg::A_FLAG, 8'h00);
         conv(3'(i), i[0], 2'(i));
      end
      v = 10'($random(seed));
      vin_all[sadc_pkg::SRC_TEMP*10 +: 10] <= v;
      exp_q.push_back({6'h00, v});
      wr(sadc_pkg::A_CTRL1, 8'h80);
      wr(sadc_pkg::A_CTRL0, {1'b0, sadc_pkg::CH_TEMP, 2'h1});
      // sensor settling wait of 200 us after switching to it
      repeat (40000) @(posedge core_clk);
      wr(sadc_pkg::A_CTRL0, {1'b0, sadc_pkg::CH_TEMP, 2'h3});
      d = 8'h02;
      for (int i = 0; i < 100 && d[1] !== 1'b0; i++) rd(sadc_pkg::A_CTRL0, d);
      rd(sadc_pkg::A_RESH, h);
      rd(sadc_pkg::A_RESL, l);
      chk("temp result", exp_q.pop_front(), {h, l});
      wr(sadc_pkg::A_FLAG, 8'h00);
      rd(sadc_pkg::A_FLAG, d);
      chk("flag cleared", 16'h0, {7'h0, irq_req, d});
      $display("test conversions done");
      v = 10'($random(seed));
      vin_all[9:0] <= v;
      wr(sadc_pkg::A_CTRL1, 8'h80);
      wr(sadc_pkg::A_CTRL0, 8'h01);
      repeat (8) @(posedge core_clk);
      wr(sadc_pkg::A_CTRL0, 8'h03);
      // stop somewhere inside the bit phase, a few bits resolved
      repeat (12) @(posedge core_clk);
      wr(sadc_pkg::A_CTRL0, 8'h01);
      repeat (3) @(posedge core_clk);
      rd(sadc_pkg::A_RESH, h);
      rd(sadc_pkg::A_RESL, l);
      rd(sadc_pkg::A_FLAG, d);
      chk("abort flag", 16'h0, {15'h0, d[0]});
      r = {h[1:0], l};
      ok = 1'b0;
      for (int j = 1; j < 8; j++)
         if ((r >> j) == (v >> j) && (r & 10'((1 << j) - 1)) == (r[j] ? 10'((1 << j) - 1) : 10'h0))
            ok = 1'b1;
      chk("partial result", 16'h1, {15'h0, ok});
      $display("test abort done");
      wr(sadc_pkg::A_CTRL1, 8'h00);
      wr(sadc_pkg::A_CTRL0, 8'h03);
      // fall asleep mid-conversion on a divided clock
      repeat (4) @(posedge core_clk);
      sleep_in <= 1'b1;
      repeat (40) @(posedge core_clk);
      rd(sadc_pkg::A_CTRL0, d);
      chk("sleep abort", 16'h1, {8'h0, d});
      rd(sadc_pkg::A_FLAG, d);
      chk("sleep flag", 16'h0, {8'h0, d});
      for (int i = 0; i < 3; i++) begin
         ien = (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h7;
         wr(sadc_pkg::A_IEN, {5'h0, ien});
         wr(sadc_pkg::A_FLAG, 8'h00);
         wake_cnt = 0;
         vec_cnt = 0;
         conv(3'h3, 1'b1, 2'h1);
         chk("wake", 16'(ien[0]), 16'(wake_cnt));
         chk("vector", 16'(ien == 3'h7), 16'(vec_cnt));
      end
      sleep_in <= 1'b0;
      wr(sadc_pkg::A_FLAG, 8'h00);
      wr(sadc_pkg::A_CTRL1, 8'h00);
      wr(sadc_pkg::A_CTRL0, 8'h03);
      repeat (6) @(posedge core_clk);
      wr(sadc_pkg::A_CTRL0, 8'h00);
      rd(sadc_pkg::A_CTRL0, d);
      chk("off abort", 16'h0, {7'h0, sh_hold, d});
      rd(sadc_pkg::A_FLAG, d);
      chk("off flag", 16'h0, {8'h0, d});
      $display("test sleep done");
      wr(sadc_pkg::A_CTRL1, 8'h60);
      wr(sadc_pkg::A_CTRL0, 8'h01);
      wr(sadc_pkg::A_CTRL0, 8'h03);
      repeat (50) @(posedge core_clk);
      chk("hold before reset", 16'h1, {15'h0, sh_hold});
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("hold after reset", 16'h0, {15'h0, sh_hold});
      rd(sadc_pkg::A_CTRL0, d);
      chk("ctrl0 after reset", 16'h0, {8'h0, d});
      $display("test reset done");
      wrap_up;
   end
endmodule
